// file: rtl/ssc_consts.svh
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

// clock
`define SSC_CLK_PERIOD_NS 8

// register byte offsets
`define SSC_REG_CTRL 8'h00
`define SSC_REG_STATUS 8'h04
`define SSC_REG_SERIAL 8'h08
`define SSC_REG_TEACH 8'h0c
`define SSC_REG_NAME 8'h10
`define SSC_REG_ACTION 8'h14
`define SSC_REG_DIAGCNT 8'h18

// field positions
`define SSC_CTRL_ADDR_LSB 0
`define SSC_STAT_FB_BIT 8
`define SSC_STAT_REFRESH_BIT 9
`define SSC_ACTION_REFRESH_BIT 0

// reset values
`define SSC_TEACH_RST 4'h8
`define SSC_SERIAL_RST 32'h0000_0000
`define SSC_NAME_RST 32'h0000_0000

// axi responses
`define SSC_RESP_OKAY 2'h0
`define SSC_RESP_SLVERR 2'h2

// chain and diagnostic commands
`define SSC_CHAIN_MAX 16
`define SSC_CMD_STATUS 4'h1
`define SSC_CMD_SERIAL 4'h2
`define SSC_CMD_TEACH 4'h3
`define SSC_CMD_NAME 4'h4

// timing
`define SSC_DIAG_BIT_NS 8000
`define SSC_DIAG_BIT_CYC (`SSC_DIAG_BIT_NS / `SSC_CLK_PERIOD_NS)
`define SSC_DIAG_FRAME_BITS 6'h21
`define SSC_FLASH_HALF_MS 250

`endif

// file: rtl/ssc_pkg.sv
package ssc_pkg;

    typedef enum logic [1:0] {
        PL_NORMAL = 2'b00,
        PL_UNEQ = 2'b01,
        PL_LOCK = 2'b10
    } ssc_pl_e;

    typedef enum logic [1:0] {
        DG_IDLE = 2'b00,
        DG_RX = 2'b01,
        DG_TX = 2'b10
    } ssc_dg_e;

    typedef struct packed {
        ssc_pl_e st;
        logic fell1;
        logic pa;
        logic pb;
        logic blk1;
        logic blk2;
        logic unequal;
        logic locked;
    } ssc_pl_s;

    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] sact;
        logic [1:0] sfb;
        logic [1:0] sdi;
        logic out1;
        logic out2;
        logic sig;
        logic led;
        logic [24:0] flash_cnt;
        logic flash;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [3:0] addr;
        logic [31:0] serial;
        logic [3:0] teach;
        logic [31:0] name;
        logic refresh;
        logic [15:0] served;
        ssc_dg_e dstate;
        logic [10:0] bcnt;
        logic [5:0] nbit;
        logic [7:0] rx;
        logic [32:0] tx;
    } ssc_top_s;

endpackage

// file: rtl/ssc_plaus_if.sv
`timescale 1ns/1ps
interface ssc_plaus_if;
    logic ch1;
    logic ch2;
    logic blk1;
    logic blk2;
    logic unequal;
    logic locked;

    modport top (output ch1, output ch2,
                 input blk1, input blk2, input unequal, input locked);
    modport mon (input ch1, input ch2,
                 output blk1, output blk2, output unequal, output locked);
endinterface

// file: rtl/ssc_plaus.sv
`timescale 1ns/1ps
module ssc_plaus
    import ssc_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // synchronised inputs and verdict
    ssc_plaus_if.mon pl
);

    ssc_pl_s q_reg;
    ssc_pl_s q_next;

    always_comb begin
        q_next = q_reg;
        q_next.pa = pl.ch1;
        q_next.pb = pl.ch2;
        case (q_reg.st)
            PL_NORMAL: begin
                // only a fall from both-high counts as unequal
                if (q_reg.pa && q_reg.pb && (pl.ch1 ^ pl.ch2)) begin
                    q_next.st = PL_UNEQ;
                    q_next.fell1 = !pl.ch1;
                end
            end
            PL_UNEQ: begin
                if (!pl.ch1 && !pl.ch2) begin
                    q_next.st = PL_NORMAL;
                end else if (pl.ch1 && pl.ch2) begin
                    q_next.st = PL_LOCK;
                end
            end
            PL_LOCK: begin
                if (!pl.ch1 && !pl.ch2) begin
                    q_next.st = PL_NORMAL;
                end
            end
            default: begin
                q_next.st = PL_NORMAL;
            end
        endcase
        q_next.unequal = (q_next.st == PL_UNEQ);
        q_next.locked = (q_next.st == PL_LOCK);
        // the channel that fell stays blocked until both go low
        q_next.blk1 = (q_next.st != PL_NORMAL) && q_next.fell1;
        q_next.blk2 = (q_next.st != PL_NORMAL) && !q_next.fell1;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign pl.blk1 = q_reg.blk1;
    assign pl.blk2 = q_reg.blk2;
    assign pl.unequal = q_reg.unequal;
    assign pl.locked = q_reg.locked;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_both_high_normal;
        q_reg.st == PL_NORMAL && pl.ch1 && pl.ch2;
    endsequence

    sequence s_one_falls;
        pl.ch1 != pl.ch2;
    endsequence

    property p_unequal_flag;
        s_both_high_normal ##1 s_one_falls |=> q_reg.unequal && !q_reg.locked;
    endproperty
    a_unequal_flag: assert property (p_unequal_flag)
        else $error("unequal fall not flagged");

    property p_lock_on_return;
        (q_reg.st == PL_UNEQ && pl.ch1 && pl.ch2)
            |=> q_reg.locked ##1 (q_reg.locked
                || ($past(pl.ch1) == 1'b0 && $past(pl.ch2) == 1'b0));
    endproperty
    a_lock_on_return: assert property (p_lock_on_return)
        else $error("return of fallen input did not lock");

    property p_release_both_low;
        (q_reg.st != PL_NORMAL && !pl.ch1 && !pl.ch2)
            |=> (q_reg.st == PL_NORMAL && !q_reg.blk1 && !q_reg.blk2);
    endproperty
    a_release_both_low: assert property (p_release_both_low)
        else $error("both-low did not release the lock");

endmodule

// file: rtl/ssc_channel_logic.sv
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "ssc_consts.svh"
module ssc_channel_logic
    import ssc_pkg::*;
#(
    parameter int unsigned FLASH_HALF_CYCLES =
        (`SSC_FLASH_HALF_MS * 1000000) / `SSC_CLK_PERIOD_NS
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // axi4-lite register slave
    input wire logic [7:0] i_axi_awaddr,
    input wire logic i_axi_awvalid,
    output logic o_axi_awready,
    input wire logic [31:0] i_axi_wdata,
    input wire logic [3:0] i_axi_wstrb,
    input wire logic i_axi_wvalid,
    output logic o_axi_wready,
    output logic [1:0] o_axi_bresp,
    output logic o_axi_bvalid,
    input wire logic i_axi_bready,
    input wire logic [7:0] i_axi_araddr,
    input wire logic i_axi_arvalid,
    output logic o_axi_arready,
    output logic [31:0] o_axi_rdata,
    output logic [1:0] o_axi_rresp,
    output logic o_axi_rvalid,
    input wire logic i_axi_rready,
    // switch inputs
    input wire logic i_actuator_present,
    input wire logic i_safety_input_ch1,
    input wire logic i_safety_input_ch2,
    input wire logic i_fieldbus_present,
    input wire logic i_diag_input,
    // switch outputs
    output logic o_safety_out_ch1,
    output logic o_safety_out_ch2,
    output logic o_signal_diag_output,
    output logic o_input_led
);

    localparam logic [24:0] FLASH_LAST = 25'(FLASH_HALF_CYCLES - 1);
    localparam logic [10:0] BIT_LAST = 11'(`SSC_DIAG_BIT_CYC - 1);
    localparam logic [10:0] FIRST_LAST =
        11'(`SSC_DIAG_BIT_CYC + (`SSC_DIAG_BIT_CYC / 2) - 1);

    ssc_top_s q_reg;
    ssc_top_s q_next;
    ssc_plaus_if pl ();

    ssc_plaus u_plaus (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .pl(pl.mon)
    );

    assign pl.ch1 = q_reg.s1[1];
    assign pl.ch2 = q_reg.s2[1];

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        logic [7:0] stat;
        logic [7:0] byte_in;
        logic [31:0] wd;
        logic [31:0] rd;
        logic rerr;
        logic ref_set;
        stat = {1'b0, pl.locked, pl.unequal, q_reg.s2[1], q_reg.s1[1],
                q_reg.out2, q_reg.out1, q_reg.sact[1]};
        byte_in = {q_reg.sdi[1], q_reg.rx[7:1]};
        wd = 32'h0000_0000;
        rd = 32'h0000_0000;
        rerr = 1'b0;
        ref_set = 1'b0;
        q_next = q_reg;

        // two-stage synchronisers; stage 0 feeds stage 1 only
        q_next.s1 = {q_reg.s1[0], i_safety_input_ch1};
        q_next.s2 = {q_reg.s2[0], i_safety_input_ch2};
        q_next.sact = {q_reg.sact[0], i_actuator_present};
        q_next.sfb = {q_reg.sfb[0], i_fieldbus_present};
        q_next.sdi = {q_reg.sdi[0], i_diag_input};

        if (q_reg.flash_cnt == FLASH_LAST) begin
            q_next.flash_cnt = 25'h0;
            q_next.flash = !q_reg.flash;
        end else begin
            q_next.flash_cnt = q_reg.flash_cnt + 25'h1;
        end

        // an absent actuator forces the safe state
        q_next.out1 = q_reg.sact[1] && q_reg.s1[1] && !pl.blk1;
        q_next.out2 = q_reg.sact[1] && q_reg.s2[1] && !pl.blk2;
        if (pl.unequal || pl.locked) begin
            q_next.led = q_reg.flash;
        end else begin
            q_next.led = q_reg.s1[1] && q_reg.s2[1];
        end

        // diagnostic link; state restarts at idle after every reset
        case (q_reg.dstate)
            DG_IDLE: begin
                if (!q_reg.sdi[1]) begin
                    q_next.dstate = DG_RX;
                    q_next.bcnt = FIRST_LAST;
                    q_next.nbit = 6'h0;
                end
            end
            DG_RX: begin
                if (q_reg.bcnt != 11'h0) begin
                    q_next.bcnt = q_reg.bcnt - 11'h1;
                end else if (q_reg.nbit != 6'h7) begin
                    q_next.rx = byte_in;
                    q_next.nbit = q_reg.nbit + 6'h1;
                    q_next.bcnt = BIT_LAST;
                end else begin
                    q_next.rx = byte_in;
                    q_next.dstate = DG_IDLE;
                    q_next.bcnt = BIT_LAST;
                    q_next.nbit = 6'h0;
                    // upper nibble picks one of the chained sensors
                    if (byte_in[7:4] == q_reg.addr) begin
                        q_next.dstate = DG_TX;
                        case (byte_in[3:0])
                            `SSC_CMD_STATUS: q_next.tx = {24'h0, stat, 1'b0};
                            `SSC_CMD_SERIAL: q_next.tx = {q_reg.serial, 1'b0};
                            `SSC_CMD_TEACH: q_next.tx = {28'h0, q_reg.teach, 1'b0};
                            `SSC_CMD_NAME: begin
                                q_next.tx = {q_reg.name, 1'b0};
                                q_next.refresh = 1'b1;
                                ref_set = 1'b1;
                            end
                            default: q_next.dstate = DG_IDLE;
                        endcase
                    end
                end
            end
            DG_TX: begin
                if (q_reg.bcnt != 11'h0) begin
                    q_next.bcnt = q_reg.bcnt - 11'h1;
                end else begin
                    q_next.tx = {1'b1, q_reg.tx[32:1]};
                    q_next.nbit = q_reg.nbit + 6'h1;
                    q_next.bcnt = BIT_LAST;
                    if (q_reg.nbit == `SSC_DIAG_FRAME_BITS) begin
                        q_next.dstate = DG_IDLE;
                        q_next.served = q_reg.served + 16'h1;
                    end
                end
            end
            default: begin
                q_next.dstate = DG_IDLE;
            end
        endcase
        // losing the module drops any frame in flight
        if (!q_reg.sfb[1]) begin
            q_next.dstate = DG_IDLE;
            q_next.rx = q_reg.rx;
        end

        if (!q_reg.sfb[1]) begin
            q_next.sig = q_reg.sact[1];
        end else if (q_reg.dstate == DG_TX) begin
            q_next.sig = q_reg.tx[0];
        end else begin
            q_next.sig = 1'b1;
        end

        // write path: address and data may arrive in either order
        if (q_reg.bvalid && i_axi_bready) begin
            q_next.bvalid = 1'b0;
        end
        if (i_axi_awvalid && q_reg.awready) begin
            q_next.aw_have = 1'b1;
            q_next.aw_addr = i_axi_awaddr;
        end
        if (i_axi_wvalid && q_reg.wready) begin
            q_next.w_have = 1'b1;
            q_next.w_data = i_axi_wdata;
            q_next.w_strb = i_axi_wstrb;
        end
        if (q_next.aw_have && q_next.w_have && !q_reg.bvalid) begin
            q_next.aw_have = 1'b0;
            q_next.w_have = 1'b0;
            q_next.bvalid = 1'b1;
            q_next.bresp = `SSC_RESP_OKAY;
            wd = q_next.w_data;
            case ({q_next.aw_addr[7:2], 2'b00})
                `SSC_REG_CTRL: begin
                    if (q_next.w_strb[0]) begin
                        q_next.addr = wd[`SSC_CTRL_ADDR_LSB +: 4];
                    end
                end
                `SSC_REG_SERIAL: begin
                    q_next.serial = merge(q_reg.serial, wd, q_next.w_strb);
                end
                `SSC_REG_TEACH: begin
                    if (q_next.w_strb[0]) begin
                        q_next.teach = wd[3:0];
                    end
                end
                `SSC_REG_NAME: begin
                    q_next.name = merge(q_reg.name, wd, q_next.w_strb);
                end
                `SSC_REG_ACTION: begin
                    // a request landing in the clearing cycle survives
                    if (q_next.w_strb[0] && wd[`SSC_ACTION_REFRESH_BIT]
                        && !ref_set) begin
                        q_next.refresh = 1'b0;
                    end
                end
                `SSC_REG_STATUS, `SSC_REG_DIAGCNT: begin
                    q_next.bresp = `SSC_RESP_OKAY;
                end
                default: q_next.bresp = `SSC_RESP_SLVERR;
            endcase
        end
        q_next.awready = !q_next.aw_have && !q_next.bvalid;
        q_next.wready = !q_next.w_have && !q_next.bvalid;

        // read path: one read in flight
        if (q_reg.rvalid && i_axi_rready) begin
            q_next.rvalid = 1'b0;
        end
        if (i_axi_arvalid && q_reg.arready) begin
            case ({i_axi_araddr[7:2], 2'b00})
                `SSC_REG_CTRL: rd = {28'h0, q_reg.addr};
                `SSC_REG_STATUS: begin
                    rd = {22'h0, q_reg.refresh, q_reg.sfb[1], stat};
                end
                `SSC_REG_SERIAL: rd = q_reg.serial;
                `SSC_REG_TEACH: rd = {28'h0, q_reg.teach};
                `SSC_REG_NAME: rd = q_reg.name;
                `SSC_REG_ACTION: rd = {31'h0, q_reg.refresh};
                `SSC_REG_DIAGCNT: rd = {16'h0, q_reg.served};
                default: rerr = 1'b1;
            endcase
            q_next.rvalid = 1'b1;
            q_next.rdata = rd;
            q_next.rresp = rerr ? `SSC_RESP_SLVERR : `SSC_RESP_OKAY;
        end
        q_next.arready = !q_next.rvalid;
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q_reg <= '0;
            q_reg.sdi <= 2'b11;
            q_reg.teach <= `SSC_TEACH_RST;
            q_reg.serial <= `SSC_SERIAL_RST;
            q_reg.name <= `SSC_NAME_RST;
        end else begin
            q_reg <= q_next;
        end
    end

    assign o_axi_awready = q_reg.awready;
    assign o_axi_wready = q_reg.wready;
    assign o_axi_bvalid = q_reg.bvalid;
    assign o_axi_bresp = q_reg.bresp;
    assign o_axi_arready = q_reg.arready;
    assign o_axi_rvalid = q_reg.rvalid;
    assign o_axi_rdata = q_reg.rdata;
    assign o_axi_rresp = q_reg.rresp;
    assign o_safety_out_ch1 = q_reg.out1;
    assign o_safety_out_ch2 = q_reg.out2;
    assign o_signal_diag_output = q_reg.sig;
    assign o_input_led = q_reg.led;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    property p_out_follows;
        (q_reg.sact[1] && q_reg.s1[1] && !pl.blk1)
            |=> o_safety_out_ch1 && ($past(q_reg.s2[1]) == o_safety_out_ch2
                || $past(pl.blk2) || !$past(q_reg.sact[1]));
    endproperty
    a_out_follows: assert property (p_out_follows)
        else $error("safety output did not follow its input");

    property p_absent_safe;
        !q_reg.sact[1] |=> !o_safety_out_ch1 && !o_safety_out_ch2;
    endproperty
    a_absent_safe: assert property (p_absent_safe)
        else $error("outputs not low without actuator");

    property p_presence_signal;
        (!q_reg.sfb[1] && !$past(q_reg.sfb[1]))
            |=> o_signal_diag_output == $past(q_reg.sact[1]);
    endproperty
    a_presence_signal: assert property (p_presence_signal)
        else $error("signal output does not show presence");

    property p_rx_start;
        (q_reg.sfb[1] && q_reg.dstate == DG_IDLE && !q_reg.sdi[1])
            |=> q_reg.dstate == DG_RX && q_reg.bcnt == FIRST_LAST;
    endproperty
    a_rx_start: assert property (p_rx_start)
        else $error("diagnostic frame start missed");

    property p_rx_ignored;
        !q_reg.sfb[1] |=> q_reg.dstate == DG_IDLE && $stable(q_reg.rx);
    endproperty
    a_rx_ignored: assert property (p_rx_ignored)
        else $error("diagnostic input used without module");

    property p_tx_drive;
        (q_reg.sfb[1] && q_reg.dstate == DG_TX)
            |=> o_signal_diag_output == $past(q_reg.tx[0]);
    endproperty
    a_tx_drive: assert property (p_tx_drive)
        else $error("signal output not carrying diagnostic data");

    property p_sync_delay;
        $rose(i_safety_input_ch1) ##1 i_safety_input_ch1 |=> q_reg.s1[1];
    endproperty
    a_sync_delay: assert property (p_sync_delay)
        else $error("input synchroniser latency wrong");

endmodule

// file: tb/ssc_fb_model.sv
`timescale 1ns/1ps
module ssc_fb_model #(
    parameter int BIT_CYCLES = 1000
) (
    // clock
    input wire logic i_clk_sys,
    // sensor to module, module to sensor
    input wire logic i_line,
    output logic o_line
);
    initial o_line = 1'b1;

    // request: start bit, then byte lsb first, upper nibble addresses one
    // subscriber of the chain, so no position-dependent wiring is needed
    task automatic send(input logic [7:0] b);
        logic [8:0] f;
        f = {b, 1'b0};
        for (int i = 0; i < 9; i++) begin
            @(posedge i_clk_sys);
            o_line <= f[i];
            repeat (BIT_CYCLES - 1) @(posedge i_clk_sys);
        end
        @(posedge i_clk_sys);
        o_line <= 1'b1;
    endtask

    // the reply may start before our stop bit ends, so run beside send
    task automatic get(output logic [31:0] v, output logic ok);
        int n;
        ok = 1'b0;
        v = 32'h0;
        for (n = 0; n < 12 * BIT_CYCLES && i_line !== 1'b0; n++)
            @(posedge i_clk_sys);
        if (i_line === 1'b0) begin
            ok = 1'b1;
            repeat (BIT_CYCLES / 2) @(posedge i_clk_sys);
            for (int i = 0; i < 32; i++) begin
                repeat (BIT_CYCLES) @(posedge i_clk_sys);
                v[i] = i_line;
            end
            // a reply without its stop bit counts as no reply
            repeat (BIT_CYCLES) @(posedge i_clk_sys);
            ok = (i_line === 1'b1);
        end
    endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
`include "ssc_consts.svh"
module tb_top;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, ok;
    logic act, in1, in2, fbp, dline, out1, out2, sig, led;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int err_total, check_count;

    ssc_channel_logic #(.FLASH_HALF_CYCLES(8)) dut (
        .i_clk_sys(clk), .i_reset_n(rst_n),
        .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
        .o_axi_awready(awready), .i_axi_wdata(wdata),
        .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid), .o_axi_wready(wready),
        .o_axi_bresp(bresp), .o_axi_bvalid(bvalid), .i_axi_bready(bready),
        .i_axi_araddr(araddr), .i_axi_arvalid(arvalid),
        .o_axi_arready(arready), .o_axi_rdata(rdata),
        .o_axi_rresp(rresp), .o_axi_rvalid(rvalid), .i_axi_rready(rready),
        .i_actuator_present(act), .i_safety_input_ch1(in1),
        .i_safety_input_ch2(in2), .i_fieldbus_present(fbp),
        .i_diag_input(dline), .o_safety_out_ch1(out1),
        .o_safety_out_ch2(out2), .o_signal_diag_output(sig),
        .o_input_led(led));
    ssc_fb_model #(.BIT_CYCLES(`SSC_DIAG_BIT_CYC)) fb (
        .i_clk_sys(clk), .i_line(sig), .o_line(dline));

    task automatic end_of_test;
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic [1:0] r;
        @(posedge clk);
        r = 2'hx;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                break;
            end
        end
        bready <= 1'b0;
        chk(32'(r), 32'(er));
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er,
                      output logic [31:0] d);
        logic [1:0] r;
        @(posedge clk);
        r = 2'hx;
        d = 32'hx;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                break;
            end
        end
        rready <= 1'b0;
        chk(32'(r), 32'(er));
    endtask

    // six cycles cover the two-flop sync plus the output flop
    task automatic drive(input logic a, input logic x, input logic y);
        @(posedge clk);
        act <= a;
        in1 <= x;
        in2 <= y;
        repeat (6) @(posedge clk);
    endtask

    task automatic flash;
        int t;
        logic p;
        t = 0;
        p = led;
        repeat (24) begin
            @(posedge clk);
            if (led !== p) t++;
            p = led;
        end
        chk(32'(t >= 2), 32'h1);
    endtask

    task automatic t_regs;
        rd(`SSC_REG_TEACH, `SSC_RESP_OKAY, v);
        chk(v, 32'h8);
        wr(`SSC_REG_SERIAL, 32'h1234_5678, `SSC_RESP_OKAY);
        rd(`SSC_REG_SERIAL, `SSC_RESP_OKAY, v);
        chk(v, 32'h1234_5678);
        wr(8'h1c, 32'h1, `SSC_RESP_SLVERR);
        rd(8'h1c, `SSC_RESP_SLVERR, v);
        chk(v, 32'h0);
        wr(`SSC_REG_STATUS, 32'hffff, `SSC_RESP_OKAY);
    endtask

    // order avoids any fall of one input while the other is high
    task automatic t_truth;
        logic [1:0] tab [6];
        tab = '{2'h0, 2'h2, 2'h0, 2'h1, 2'h0, 2'h3};
        foreach (tab[i]) begin
            drive(1'b1, tab[i][1], tab[i][0]);
            chk(32'({out1, out2, sig}), 32'({tab[i], 1'b1}));
        end
        drive(1'b0, 1'b1, 1'b1);
        chk(32'({out1, out2, sig}), 32'h0);
        drive(1'b1, 1'b1, 1'b1);
    endtask

    task automatic t_plaus;
        drive(1'b1, 1'b0, 1'b1);
        chk(32'({out1, out2}), 32'h1);
        flash();
        drive(1'b1, 1'b1, 1'b1);
        chk(32'({out1, out2}), 32'h1);
        flash();
        rd(`SSC_REG_STATUS, `SSC_RESP_OKAY, v);
        chk(32'(v[6]), 32'h1);
        drive(1'b1, 1'b0, 1'b0);
        drive(1'b1, 1'b1, 1'b1);
        chk(32'({out1, out2, led}), 32'h7);
    endtask

    task automatic t_diag;
        // a second power-up: the link must come back by itself
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        wr(`SSC_REG_CTRL, 32'h3, `SSC_RESP_OKAY);
        @(posedge clk);
        fbp <= 1'b1;
        repeat (8) @(posedge clk);
        chk(32'(sig), 32'h1);
        fork
            fb.send(8'h31);
            fb.get(v, ok);
        join
        chk(v, 32'h1f);
        chk(32'(ok), 32'h1);
        // the reply counter steps only once the stop bit has ended
        repeat (`SSC_DIAG_BIT_CYC) @(posedge clk);
        rd(`SSC_REG_DIAGCNT, `SSC_RESP_OKAY, v);
        chk(v, 32'h1);
        @(posedge clk);
        fbp <= 1'b0;
        repeat (8) @(posedge clk);
        fork
            fb.send(8'h31);
            fb.get(v, ok);
        join
        chk(32'(ok), 32'h0);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (80000) @(posedge clk);
        err_total++;
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {act, in1, in2, fbp} = 4'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
        err_total = 0;
        check_count = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_regs();
        t_truth();
        t_plaus();
        t_diag();
        end_of_test();
    end
endmodule
